// ==== frbg_channel.v ====
// Function
// - fifo on: tx level asserted below trigger or empty, polarity per mode.
// - fifo on: rx level asserted above trigger, polarity from bus pin.
// - host reads and writes complete without any oscillator running.
// - oscillator feeds the rate generator and is driven out buffered.
// - modem control bit 7 selects prescale divide by 1 or 4.
// - divisor spans 1 to 65536 plus 15/16 in sixteenth steps.
// - reset divisor is one: low 0x01, high and fraction 0x00.
// - fraction keeps four low bits; two bytes form integer part.
// - enhanced mode bit 7 selects 16x when set, 8x when clear.
// - 8x mode with odd fraction lets bit time jitter one prescaled clock.
// - sampling tick times both transmit shifting and receive sampling.
`timescale 1ns/100ps
`include "frbg_consts.vh"

module frbg_channel #(
	parameter INT_W = 16,
	parameter FRAC_W = 4
) (
	input wire clk,
	input wire rst_n,
	input wire imSel,
	input wire csN,
	input wire iorN,
	input wire iowN,
	input wire rwN,
	input wire [2:0] addr,
	input wire [7:0] dataIn,
	output wire [7:0] dataOut,
	output wire dataOe,
	input wire txHoldEmpty,
	input wire rxHoldFull,
	input wire txFifoLow,
	input wire rxFifoHigh,
	output wire intPin,
	output wire oscBufferedOut,
	output wire sampleTick,
	output wire bitTick
);

	// reset images trimmed to the implemented widths
	localparam [7:0] RST_FRAC_BYTE = `FRBG_RST_DIV_FRAC;
	localparam [7:0] RST_LOW_BYTE = `FRBG_RST_DIV_LOW;
	localparam [FRAC_W-1:0] RST_FRAC = RST_FRAC_BYTE[FRAC_W-1:0];
	localparam [INT_W-1:0] RST_INT = {{(INT_W-8){1'b0}}, RST_LOW_BYTE};

	// pin level for a request: high-true when the strap is set
	function pinLevel;
		input req;
		input highTrue;
		begin
			if (highTrue)
				pinLevel = req;
			else
				pinLevel = ~req;
		end
	endfunction

	// one-hot register select from the host address
	function [5:0] regSel;
		input [2:0] a;
		begin
			regSel = 6'h00;
			case (a)
				`FRBG_OFS_DIV_LOW: regSel = 6'h01;
				`FRBG_OFS_DIV_HIGH: regSel = 6'h02;
				`FRBG_OFS_FIFO_CTL: regSel = 6'h04;
				`FRBG_OFS_DIV_FRAC: regSel = 6'h08;
				`FRBG_OFS_MODEM_CTL: regSel = 6'h10;
				`FRBG_OFS_ENH_MODE: regSel = 6'h20;
				default: regSel = 6'h00;
			endcase
		end
	endfunction

	// host-side registers, clocked by the write strobe itself
	reg [7:0] divLowReg;
	reg [7:0] divHighReg;
	reg [FRAC_W-1:0] divFracReg;
	reg [7:0] fifoCtlReg;
	reg [7:0] modemCtlReg;
	reg [7:0] enhModeReg;
	reg wrToggleReg;
	wire wrStrobe;
	wire rdStrobe;
	wire [5:0] wrSel;
	wire [5:0] rdSel;
	reg [7:0] rdData;

	// strobe decode for both bus styles; no oscillator involved
	assign wrStrobe = imSel ? (~csN & ~iowN) : (~csN & ~rwN);
	assign rdStrobe = imSel ? (~csN & ~iorN) : (~csN & rwN);
	assign wrSel = regSel(addr);
	assign rdSel = regSel(addr);

	// write is taken at the trailing edge of the strobe
	always @(negedge wrStrobe or negedge rst_n) begin
		if (!rst_n) begin
			divLowReg <= `FRBG_RST_DIV_LOW;
			divHighReg <= `FRBG_RST_DIV_HIGH;
			divFracReg <= RST_FRAC;
			fifoCtlReg <= `FRBG_RST_FIFO_CTL;
			modemCtlReg <= `FRBG_RST_MODEM_CTL;
			enhModeReg <= `FRBG_RST_ENH_MODE;
			wrToggleReg <= 1'b0;
		end else begin
			if (wrSel[0])
				divLowReg <= dataIn;
			if (wrSel[1])
				divHighReg <= dataIn;
			if (wrSel[2])
				fifoCtlReg <= dataIn;
			if (wrSel[3])
				divFracReg <= dataIn[FRAC_W-1:0];
			if (wrSel[4])
				modemCtlReg <= dataIn;
			if (wrSel[5])
				enhModeReg <= dataIn;
			wrToggleReg <= ~wrToggleReg;
		end
	end

	// read mux, purely combinational so reads need no clock
	always @* begin
		rdData = `FRBG_RD_UNMAPPED;
		case (1'b1)
			rdSel[0]: rdData = divLowReg;
			rdSel[1]: rdData = divHighReg;
			rdSel[2]: rdData = fifoCtlReg;
			rdSel[3]: rdData = {{(8-FRAC_W){1'b0}}, divFracReg};
			rdSel[4]: rdData = modemCtlReg;
			rdSel[5]: rdData = enhModeReg;
			default: rdData = `FRBG_RD_UNMAPPED;
		endcase
	end

	assign dataOut = rdData;
	assign dataOe = rdStrobe;

	// buffered oscillator copy for other devices
	assign oscBufferedOut = clk;

	// oscillator-side state
	reg togSync1Reg;
	reg togSync2Reg;
	reg togSeenReg;
	reg imSync1Reg;
	reg imSync2Reg;
	reg fifoEnReg;
	reg prescaleReg;
	reg mode16Reg;
	reg [INT_W-1:0] pendIntReg;
	reg [FRAC_W-1:0] pendFracReg;
	reg [1:0] preCntReg;
	reg [INT_W:0] divCntReg;
	reg [FRAC_W-1:0] accReg;
	reg sampleTickReg;
	reg [3:0] bitCntReg;
	reg bitTickReg;
	reg intReg;

	wire wrSeen;
	wire preTick;
	wire boundary;
	wire [FRAC_W:0] accSum;
	wire [INT_W:0] intFull;
	wire [INT_W:0] divCntNext;
	wire [3:0] bitLast;
	wire txLevel;
	wire rxLevel;

	// write event crosses by toggle; host data is stable by then
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			togSync1Reg <= 1'b0;
			togSync2Reg <= 1'b0;
			togSeenReg <= 1'b0;
			imSync1Reg <= 1'b0;
			imSync2Reg <= 1'b0;
		end else begin
			togSync1Reg <= wrToggleReg;
			togSync2Reg <= togSync1Reg;
			togSeenReg <= togSync2Reg;
			imSync1Reg <= imSel;
			imSync2Reg <= imSync1Reg;
		end
	end

	assign wrSeen = togSync2Reg ^ togSeenReg;

	// copy host settings into the oscillator domain after each write
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			fifoEnReg <= 1'b0;
			prescaleReg <= 1'b0;
			mode16Reg <= 1'b0;
			pendIntReg <= RST_INT;
			pendFracReg <= RST_FRAC;
		end else if (wrSeen) begin
			fifoEnReg <= fifoCtlReg[`FRBG_FIFO_EN_BIT];
			prescaleReg <= modemCtlReg[`FRBG_PRESCALE_BIT];
			mode16Reg <= enhModeReg[`FRBG_MODE16_BIT];
			pendIntReg <= {divHighReg, divLowReg};
			pendFracReg <= divFracReg;
		end
	end

	// prescaler: every clock or every fourth clock
	reg preTickSel;
	always @* begin
		preTickSel = 1'b1;
		if (prescaleReg)
			preTickSel = (preCntReg == `FRBG_PRESCALE_LAST);
	end
	assign preTick = preTickSel;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			preCntReg <= 2'h0;
		else if (prescaleReg)
			preCntReg <= preCntReg + 2'h1;
		else
			preCntReg <= 2'h0;
	end

	// fractional divider; integer zero counts as full range
	assign boundary = preTick && (divCntReg == {(INT_W+1){1'b0}});
	assign accSum = {1'b0, accReg} + {1'b0, pendFracReg};
	assign intFull = (pendIntReg == {INT_W{1'b0}}) ?
		{1'b1, {INT_W{1'b0}}} : {1'b0, pendIntReg};
	assign divCntNext = intFull - {{INT_W{1'b0}}, 1'b1}
		+ {{INT_W{1'b0}}, accSum[FRAC_W]};

	// new divisor is sampled only at the period boundary
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			divCntReg <= {(INT_W+1){1'b0}};
			accReg <= {FRAC_W{1'b0}};
			sampleTickReg <= 1'b0;
		end else begin
			sampleTickReg <= boundary;
			if (boundary) begin
				divCntReg <= divCntNext;
				accReg <= accSum[FRAC_W-1:0];
			end else if (preTick) begin
				divCntReg <= divCntReg - {{INT_W{1'b0}}, 1'b1};
			end
		end
	end

	// bit time of 16 or 8 sampling ticks; 8x shows fraction jitter
	reg [3:0] bitLastSel;
	always @* begin
		bitLastSel = `FRBG_BIT_LAST_8X;
		if (mode16Reg)
			bitLastSel = `FRBG_BIT_LAST_16X;
	end
	assign bitLast = bitLastSel;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			bitCntReg <= 4'h0;
			bitTickReg <= 1'b0;
		end else begin
			bitTickReg <= boundary && (bitCntReg >= bitLast);
			if (boundary) begin
				if (bitCntReg >= bitLast)
					bitCntReg <= 4'h0;
				else
					bitCntReg <= bitCntReg + 4'h1;
			end
		end
	end

	assign sampleTick = sampleTickReg;
	assign bitTick = bitTickReg;

	// interrupt level from holding or fifo state
	assign txLevel = fifoEnReg ? txFifoLow : txHoldEmpty;
	assign rxLevel = fifoEnReg ? rxFifoHigh : rxHoldFull;

	// tx and rx requests share the pin
	wire anyLevel;
	wire intNext;
	assign anyLevel = txLevel | rxLevel;
	assign intNext = pinLevel(anyLevel, imSync2Reg);

	// pin polarity follows bus type: high-true or low-true
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			intReg <= 1'b0;
		else
			intReg <= intNext;
	end

	assign intPin = intReg;

endmodule

// ==== frbg_consts.vh ====
`ifndef FRBG_CONSTS_VH
`define FRBG_CONSTS_VH

// register offsets on the 3-bit host address
`define FRBG_OFS_DIV_LOW 3'h0
`define FRBG_OFS_DIV_HIGH 3'h1
`define FRBG_OFS_FIFO_CTL 3'h2
`define FRBG_OFS_DIV_FRAC 3'h3
`define FRBG_OFS_MODEM_CTL 3'h4
`define FRBG_OFS_ENH_MODE 3'h5

// reset values
`define FRBG_RST_DIV_LOW 8'h01
`define FRBG_RST_DIV_HIGH 8'h00
`define FRBG_RST_DIV_FRAC 8'h00
`define FRBG_RST_FIFO_CTL 8'h00
`define FRBG_RST_MODEM_CTL 8'h00
`define FRBG_RST_ENH_MODE 8'h00
`define FRBG_RD_UNMAPPED 8'h00

// field positions
`define FRBG_FIFO_EN_BIT 0
`define FRBG_PRESCALE_BIT 7
`define FRBG_MODE16_BIT 7

// timing counts
`define FRBG_PRESCALE_LAST 2'h3
`define FRBG_BIT_LAST_16X 4'hf
`define FRBG_BIT_LAST_8X 4'h7

`endif

// ==== frbg_asserts.sv ====
`timescale 1ns/100ps
module frbg_checker (
	input wire clk,
	input wire rst_n,
	input wire imSel,
	input wire csN,
	input wire iorN,
	input wire rwN,
	input wire [2:0] addr,
	input wire [7:0] dataOut,
	input wire dataOe,
	input wire txHoldEmpty,
	input wire rxHoldFull,
	input wire txFifoLow,
	input wire rxFifoHigh,
	input wire intPin,
	input wire oscBufferedOut,
	input wire sampleTick,
	input wire bitTick
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// all level sources raised or all dropped
	wire allHi = txHoldEmpty & rxHoldFull & txFifoLow & rxFifoHigh;
	wire allLo = !(txHoldEmpty | rxHoldFull | txFifoLow | rxFifoHigh);
	sequence sBusy;
		allHi && $stable(imSel);
	endsequence
	sequence sIdle;
		allLo && $stable(imSel);
	endsequence
	a_int_busy: assert property (sBusy [*3] |=> intPin == imSel)
		else $error("interrupt not asserted");
	a_int_idle: assert property (sIdle [*3] |=> intPin != imSel)
		else $error("interrupt not released");
	a_osc_copy: assert property (oscBufferedOut == clk)
		else $error("buffered oscillator differs");
	a_read_oe: assert property (dataOe == (!csN && (imSel ? !iorN : rwN)))
		else $error("read enable wrong");
	a_read_gap: assert property (dataOe && addr >= 3'h6 |-> dataOut == 8'h00)
		else $error("unmapped read not zero");
	a_bit_group: assert property (bitTick |-> sampleTick ##1 !bitTick [*7])
		else $error("bit tick grouping wrong");
	a_first_tick: assert property ($rose(rst_n) |=> sampleTick)
		else $error("no tick after reset");
	a_reset_quiet: assert property ($rose(rst_n) |-> !sampleTick && !intPin)
		else $error("outputs busy at reset");
endmodule

// ==== frbg_host_cpu.sv ====
`timescale 1ns/100ps
module frbg_host_cpu (
	input wire clk,
	input wire imSel,
	input wire [7:0] dataOut,
	output logic csN,
	output logic iorN,
	output logic iowN,
	output logic rwN,
	output logic [2:0] addr,
	output logic [7:0] dataIn
);
	initial begin
		{csN, iorN, iowN, rwN} = 4'hf;
		addr = 3'h0;
		dataIn = 8'h00;
	end
	// one strobe cycle; released lines flip so no value lingers
	task automatic access(input bit wr, input [2:0] a, input [7:0] d,
		output [7:0] q);
		@(posedge clk);
		#1;
		addr = a;
		dataIn = d;
		csN = 1'b0;
		iowN = !(imSel && wr);
		iorN = !(imSel && !wr);
		rwN = !(!imSel && wr);
		@(posedge clk);
		q = dataOut;
		#1;
		{csN, iorN, iowN} = 3'h7;
		#1;
		rwN = 1'b1;
		addr = ~a;
		dataIn = ~d;
		repeat (4) @(posedge clk); // spacing for the crossing
	endtask
	// split divisor into bytes
	task automatic prog(input int i, input int f);
		logic [7:0] q;
		access(1'b1, 3'h1, 8'(i >> 8), q);
		access(1'b1, 3'h0, 8'(i & 8'hff), q);
		access(1'b1, 3'h3, 8'(f), q);
	endtask
endmodule

// ==== tb.sv ====
`timescale 1ns/100ps
module tb;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic imSel = 1'b1;
	logic [3:0] lv = 4'h0;
	wire csN, iorN, iowN, rwN, dataOe, intPin, oscBufferedOut;
	wire sampleTick, bitTick;
	wire [2:0] addr;
	wire [7:0] dataIn, dataOut;
	int fail_count = 0;
	int compares = 0;
	int seed = 67599;
	int i, f, p, m, t0, lvl;
	logic [7:0] q;
	always #50 clk = ~clk;
	frbg_channel uut (.clk(clk), .rst_n(rst_n), .imSel(imSel), .csN(csN),
		.iorN(iorN), .iowN(iowN), .rwN(rwN), .addr(addr), .dataIn(dataIn),
		.dataOut(dataOut), .dataOe(dataOe), .txHoldEmpty(lv[0]),
		.rxHoldFull(lv[1]), .txFifoLow(lv[2]), .rxFifoHigh(lv[3]),
		.intPin(intPin), .oscBufferedOut(oscBufferedOut),
		.sampleTick(sampleTick), .bitTick(bitTick));
	frbg_host_cpu cpu (.clk(clk), .imSel(imSel), .dataOut(dataOut),
		.csN(csN), .iorN(iorN), .iowN(iowN), .rwN(rwN), .addr(addr),
		.dataIn(dataIn));
	function automatic int rnd(input int n);
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return (seed & 32'h7fffffff) % n;
	endfunction
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("mismatches %0d, compares %0d", fail_count, compares);
		if (fail_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// bounded wait for the next bit tick
	task automatic wait_bit;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			#1;
			n++;
		end while (bitTick !== 1'b1 && n < 2000);
		if (n >= 2000) begin
			fail_count++;
			tally_and_finish;
		end
	endtask
	initial begin
		repeat (20) @(posedge clk);
		#1;
		rst_n = 1'b1;
		// reset values and the fraction width
		cpu.access(1'b0, 3'h0, 8'h00, q);
		check(q, 8'h01);
		cpu.access(1'b0, 3'h1, 8'h00, q);
		check(q, 8'h00);
		cpu.access(1'b0, 3'h3, 8'h00, q);
		check(q, 8'h00);
		cpu.access(1'b1, 3'h3, 8'hff, q);
		cpu.access(1'b0, 3'h3, 8'h00, q);
		check(q, 8'h0f);
		cpu.access(1'b1, 3'h6, 8'h5a, q);
		cpu.access(1'b0, 3'h6, 8'h00, q);
		check(q, 8'h00);
		// random divisors: sixteen sample periods span 16i+f clocks, four times that with prescale set
		repeat (6) begin
			i = 1 + rnd(5);
			f = rnd(16);
			p = rnd(2);
			m = rnd(2);
			cpu.prog(i, f);
			cpu.access(1'b1, 3'h4, 8'(p << 7), q);
			cpu.access(1'b1, 3'h5, 8'(m << 7), q);
			wait_bit;
			wait_bit;
			t0 = $time;
			wait_bit;
			if (m == 0)
				wait_bit;
			check(($time - t0) / 100, (p ? 4 : 1) * (16 * i + f));
		end
		// interrupt levels in both bus modes and both fifo settings
		for (int ph = 0; ph < 2; ph++) begin
			for (int fe = 0; fe < 2; fe++) begin
				cpu.access(1'b1, 3'h2, 8'(fe), q);
				for (int j = 0; j < 8; j++) begin
					lv = (j == 0) ? 4'h0 : (j == 1) ? 4'hf : 4'(rnd(16));
					repeat (3) @(posedge clk);
					#1;
					lvl = fe ? (lv[2] | lv[3]) : (lv[0] | lv[1]);
					check(intPin, imSel ? lvl : !lvl);
				end
			end
			rst_n = 1'b0;
			imSel = 1'b0;
			repeat (3) @(posedge clk);
			#1;
			rst_n = 1'b1;
			repeat (4) @(posedge clk);
		end
		tally_and_finish;
	end
endmodule
bind frbg_channel frbg_checker chk (.clk(clk), .rst_n(rst_n),
	.imSel(imSel), .csN(csN), .iorN(iorN), .rwN(rwN), .addr(addr),
	.dataOut(dataOut), .dataOe(dataOe), .txHoldEmpty(txHoldEmpty),
	.rxHoldFull(rxHoldFull), .txFifoLow(txFifoLow),
	.rxFifoHigh(rxFifoHigh), .intPin(intPin),
	.oscBufferedOut(oscBufferedOut), .sampleTick(sampleTick),
	.bitTick(bitTick));
